// [rtl/ssr_conv.v]
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.vh"

module ssr_conv (
    input  wire [`SSR_DATA_W-1:0] in_data,
    input  wire [`SSR_TYPE_W-1:0] in_type,
    input  wire [`SSR_TYPE_W-1:0] want_type,
    input  wire                   dflt_en,
    input  wire [`SSR_DATA_W-1:0] dflt_val,
    output reg  [`SSR_DATA_W-1:0] out_data,
    output reg  [`SSR_TYPE_W-1:0] out_type,
    output reg                    out_conv,
    output reg                    out_sat
);

    reg [4:0]  lead;
    reg [31:0] norm;
    reg [7:0]  expo;
    reg [31:0] full;
    reg [7:0]  shamt;
    integer    i;

    always @* begin
        out_data = `SSR_U_ZERO;
        out_type = in_type;
        out_conv = 1'b0;
        out_sat  = 1'b0;
        lead     = 5'h00;
        norm     = 32'h0000_0000;
        expo     = in_data[`SSR_F_EXP_HI:`SSR_F_EXP_LO];
        full     = {1'b1, in_data[`SSR_F_MAN_HI:0], 8'h00};
        shamt    = `SSR_F_TOP_EXP - expo;
        for (i = 0; i < `SSR_DATA_W; i = i + 1) begin
            if (in_data[i]) begin
                lead = i[4:0];
            end
        end
        if (in_type == `SSR_TYPE_UNDEF) begin
            // Never turned into a number; a default stands in when given.
            out_data = dflt_en ? dflt_val : `SSR_U_ZERO;
        end else if (in_type == want_type || want_type == `SSR_TYPE_UNDEF) begin
            out_data = in_data;
        end else if (want_type == `SSR_TYPE_CONT) begin
            // Below 2^24 the result is exact; above it low bits are truncated.
            out_type = `SSR_TYPE_CONT;
            out_conv = 1'b1;
            norm     = in_data << (`SSR_MSB_POS - lead);
            if (in_data != `SSR_U_ZERO) begin
                out_data = {1'b0, `SSR_F_BIAS + {3'h0, lead}, norm[30:8]};
            end else begin
                out_data = `SSR_F_ZERO;
            end
        end else begin
            out_type = `SSR_TYPE_DISC;
            out_conv = 1'b1;
            if (in_data[`SSR_F_SIGN]) begin
                out_data = `SSR_U_ZERO;
            end else if (expo < `SSR_F_BIAS) begin
                out_data = `SSR_U_ZERO;
            end else if (expo >= `SSR_F_SAT_EXP) begin
                out_data = `SSR_U_MAX;
                out_sat  = 1'b1;
            end else begin
                out_data = full >> shamt[4:0];
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/ssr_regs.vh]
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// Sizes of the routing fabric.
`define SSR_NUM_SINKS      8
`define SSR_SINK_IDX_W     3
`define SSR_CODE_W         6
`define SSR_NUM_W          2
`define SSR_DATA_W         32
`define SSR_TYPE_W         2
`define SSR_SLOTS          192
`define SSR_SLOTS_PER_CODE 4

// Signal type tags.
`define SSR_TYPE_UNDEF     2'h0
`define SSR_TYPE_DISC      2'h1
`define SSR_TYPE_CONT      2'h2

// Source selection codes.
`define SSR_SRC_NONE       6'h00
`define SSR_SRC_RATE_XYZ   6'h01
`define SSR_SRC_GTEMP_XYZ  6'h06
`define SSR_SRC_ACC_XYZ    6'h09
`define SSR_SRC_BIN_FIRST  6'h1D
`define SSR_SRC_BIN_LAST   6'h26
`define SSR_SRC_BUS_FIRST  6'h27
`define SSR_SRC_BUS_LAST   6'h29
`define SSR_SRC_CONST_DISC 6'h2A
`define SSR_SRC_CONST_CONT 6'h2B
`define SSR_SRC_ZERO       6'h2C
`define SSR_SRC_ONE        6'h2D
`define SSR_SRC_SUPPLY     6'h2E
`define SSR_SRC_TEMP       6'h2F
`define SSR_SRC_LAST       6'h2F

// Axis numbers.
`define SSR_NUM_NONE       2'h0
`define SSR_NUM_X          2'h1
`define SSR_NUM_Z          2'h3

// Single precision float layout.
`define SSR_F_SIGN         31
`define SSR_F_EXP_HI       30
`define SSR_F_EXP_LO       23
`define SSR_F_MAN_HI       22
`define SSR_F_BIAS         8'h7F
`define SSR_F_TOP_EXP      8'h9E
`define SSR_F_SAT_EXP      8'h9F
`define SSR_F_ZERO         32'h0000_0000
`define SSR_F_ONE          32'h3F80_0000
`define SSR_U_MAX          32'hFFFF_FFFF
`define SSR_U_ZERO         32'h0000_0000
`define SSR_U_ONE          32'h0000_0001
`define SSR_MSB_POS        5'h1F

`endif

// [rtl/ssr_router.v]
// Contract
// - each block keeps its own readable, writable configuration
// - any input may take any output, unlimited fan-out
// - signals tagged undefined, discrete or continuous
// - undefined means no signal or unconnected
// - discrete values are 32-bit unsigned
// - continuous values float, physical units, scaled per block
// - mismatched defined types convert automatically
// - discrete to continuous keeps same non-negative value (exact here only up to 2^24; above it low bits are truncated)
// - continuous to discrete truncates toward zero
// - too large continuous saturates to all ones
// - negative continuous becomes discrete zero
// - undefined never converted; default value used instead
// - source codes 0 to 47 as listed
// - number picks axis X,Y,Z; otherwise ignored
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.vh"

module ssr_router (
    input  wire                                      core_clk,
    input  wire                                      rst_n,
    input  wire [`SSR_SLOTS*`SSR_DATA_W-1:0]         src_data,
    input  wire [`SSR_SLOTS*`SSR_TYPE_W-1:0]         src_type,
    input  wire [`SSR_DATA_W-1:0]                    const_disc,
    input  wire [`SSR_DATA_W-1:0]                    const_cont,
    input  wire                                      cfg_we,
    input  wire [`SSR_SINK_IDX_W-1:0]                cfg_sink,
    input  wire [`SSR_CODE_W-1:0]                    cfg_code,
    input  wire [`SSR_NUM_W-1:0]                     cfg_num,
    input  wire [`SSR_TYPE_W-1:0]                    cfg_want,
    input  wire                                      cfg_dflt_en,
    input  wire [`SSR_DATA_W-1:0]                    cfg_dflt,
    output reg  [`SSR_CODE_W-1:0]                    rd_code_r,
    output reg  [`SSR_NUM_W-1:0]                     rd_num_r,
    output reg  [`SSR_TYPE_W-1:0]                    rd_want_r,
    output reg                                       rd_dflt_en_r,
    output reg  [`SSR_DATA_W-1:0]                    rd_dflt_r,
    output reg  [`SSR_NUM_SINKS*`SSR_DATA_W-1:0]     sink_data_r,
    output reg  [`SSR_NUM_SINKS*`SSR_TYPE_W-1:0]     sink_type_r,
    output reg  [`SSR_NUM_SINKS-1:0]                 sink_conv_r,
    output reg  [`SSR_NUM_SINKS-1:0]                 sink_sat_r,
    output reg  [`SSR_NUM_SINKS-1:0]                 sink_upd_r
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // A code names a three-axis source only for the axis groups.
    function is_axis;
        input [`SSR_CODE_W-1:0] code;
        begin
            is_axis = (code == `SSR_SRC_RATE_XYZ) ||
                      (code == `SSR_SRC_GTEMP_XYZ) ||
                      (code == `SSR_SRC_ACC_XYZ);
        end
    endfunction

    // Codes beyond the list select nothing and must not index past the bundle.
    function in_range;
        input [`SSR_CODE_W-1:0] code;
        begin
            in_range = (code <= `SSR_SRC_LAST);
        end
    endfunction

    // Slot in the source bundle; the axis number only counts for axis groups.
    function [7:0] slot_of;
        input [`SSR_CODE_W-1:0] code;
        input [`SSR_NUM_W-1:0]  num;
        reg   [`SSR_NUM_W-1:0]  sub;
        begin
            sub = `SSR_NUM_NONE;
            if (is_axis(code) && num >= `SSR_NUM_X && num <= `SSR_NUM_Z) begin
                sub = num;
            end
            slot_of = {code, sub};
            if (!in_range(code)) begin
                slot_of = {`SSR_SRC_NONE, `SSR_NUM_NONE};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Per-input configuration store.

    reg [`SSR_CODE_W-1:0] code_r    [0:`SSR_NUM_SINKS-1];
    reg [`SSR_NUM_W-1:0]  num_r     [0:`SSR_NUM_SINKS-1];
    reg [`SSR_TYPE_W-1:0] want_r    [0:`SSR_NUM_SINKS-1];
    reg                   dflt_en_r [0:`SSR_NUM_SINKS-1];
    reg [`SSR_DATA_W-1:0] dflt_r    [0:`SSR_NUM_SINKS-1];

    // All fields of one input change on one edge, so a half-written route never shows.
    genvar g;
    generate
        for (g = 0; g < `SSR_NUM_SINKS; g = g + 1) begin : g_cfg
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    code_r[g]    <= `SSR_SRC_NONE;
                    num_r[g]     <= `SSR_NUM_NONE;
                    want_r[g]    <= `SSR_TYPE_UNDEF;
                    dflt_en_r[g] <= 1'b0;
                    dflt_r[g]    <= `SSR_U_ZERO;
                end else if (cfg_we && cfg_sink == g) begin
                    code_r[g]    <= cfg_code;
                    num_r[g]     <= cfg_num;
                    want_r[g]    <= cfg_want;
                    dflt_en_r[g] <= cfg_dflt_en;
                    dflt_r[g]    <= cfg_dflt;
                end
            end
        end
    endgenerate

    // Readback shows the stored setting of the addressed input.
    // It trails cfg_sink by one edge, so a write shows on the edge after it lands.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_code_r    <= `SSR_SRC_NONE;
            rd_num_r     <= `SSR_NUM_NONE;
            rd_want_r    <= `SSR_TYPE_UNDEF;
            rd_dflt_en_r <= 1'b0;
            rd_dflt_r    <= `SSR_U_ZERO;
        end else begin
            rd_code_r    <= code_r[cfg_sink];
            rd_num_r     <= num_r[cfg_sink];
            rd_want_r    <= want_r[cfg_sink];
            rd_dflt_en_r <= dflt_en_r[cfg_sink];
            rd_dflt_r    <= dflt_r[cfg_sink];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Source selection and conversion, one path per input.

    generate
        for (g = 0; g < `SSR_NUM_SINKS; g = g + 1) begin : g_sink
            reg  [`SSR_DATA_W-1:0] sel_data;
            reg  [`SSR_TYPE_W-1:0] sel_type;
            wire [7:0]             slot;
            wire [`SSR_DATA_W-1:0] cv_data;
            wire [`SSR_TYPE_W-1:0] cv_type;
            wire                   cv_conv;
            wire                   cv_sat;

            assign slot = slot_of(code_r[g], num_r[g]);

            // Constants, no-source and out-of-range codes are produced here; every other code reads the bundle.
            // Any output slot may feed any number of inputs.
            always @* begin
                sel_data = src_data[slot*`SSR_DATA_W +: `SSR_DATA_W];
                sel_type = src_type[slot*`SSR_TYPE_W +: `SSR_TYPE_W];
                case (code_r[g])
                    `SSR_SRC_NONE: begin
                        sel_data = `SSR_U_ZERO;
                        sel_type = `SSR_TYPE_UNDEF;
                    end
                    `SSR_SRC_CONST_DISC: begin
                        sel_data = const_disc;
                        sel_type = `SSR_TYPE_DISC;
                    end
                    `SSR_SRC_CONST_CONT: begin
                        sel_data = const_cont;
                        sel_type = `SSR_TYPE_CONT;
                    end
                    `SSR_SRC_ZERO: begin
                        sel_data = `SSR_U_ZERO;
                        sel_type = `SSR_TYPE_DISC;
                    end
                    `SSR_SRC_ONE: begin
                        sel_data = `SSR_U_ONE;
                        sel_type = `SSR_TYPE_DISC;
                    end
                    default: begin
                        if (!in_range(code_r[g])) begin
                            sel_data = `SSR_U_ZERO;
                            sel_type = `SSR_TYPE_UNDEF;
                        end
                    end
                endcase
            end

            // Each input owns a converter; sharing one would cost a cycle per input.
            ssr_conv u_conv (
                .in_data   (sel_data),
                .in_type   (sel_type),
                .want_type (want_r[g]),
                .dflt_en   (dflt_en_r[g]),
                .dflt_val  (dflt_r[g]),
                .out_data  (cv_data),
                .out_type  (cv_type),
                .out_conv  (cv_conv),
                .out_sat   (cv_sat)
            );

            // Refreshed every cycle so an input lags its source by one edge.
            always @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sink_data_r[g*`SSR_DATA_W +: `SSR_DATA_W] <= `SSR_U_ZERO;
                    sink_type_r[g*`SSR_TYPE_W +: `SSR_TYPE_W] <= `SSR_TYPE_UNDEF;
                    sink_conv_r[g] <= 1'b0;
                    sink_sat_r[g]  <= 1'b0;
                    sink_upd_r[g]  <= 1'b0;
                end else begin
                    sink_data_r[g*`SSR_DATA_W +: `SSR_DATA_W] <= cv_data;
                    sink_type_r[g*`SSR_TYPE_W +: `SSR_TYPE_W] <= cv_type;
                    sink_conv_r[g] <= cv_conv;
                    sink_sat_r[g]  <= cv_sat;
                    // The flag rises on the same edge that shows the new value.
                    sink_upd_r[g]  <= (cv_data != sink_data_r[g*`SSR_DATA_W +: `SSR_DATA_W]) ||
                                      (cv_type != sink_type_r[g*`SSR_TYPE_W +: `SSR_TYPE_W]);
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// [verification/ssr_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.vh"
module ssr_props (
    input wire logic          core_clk,
    input wire logic          rst_n,
    input wire logic [6143:0] src_data,
    input wire logic [383:0]  src_type,
    input wire logic          cfg_we,
    input wire logic [2:0]    cfg_sink,
    input wire logic [5:0]    cfg_code,
    input wire logic [1:0]    cfg_want,
    input wire logic          cfg_dflt_en,
    input wire logic [31:0]   cfg_dflt,
    input wire logic [5:0]    rd_code_r,
    input wire logic [255:0]  sink_data_r,
    input wire logic [15:0]   sink_type_r,
    input wire logic [7:0]    sink_conv_r,
    input wire logic [7:0]    sink_sat_r
);
    // Shadow of the setting of input 1, the input that the bench converts on.
    logic [5:0]  c1_code_r;
    logic [1:0]  c1_want_r;
    logic        c1_den_r;
    logic [31:0] c1_dflt_r;
    wire  [31:0] s_d = src_data[156*32+:32];
    wire  [1:0]  s_t = src_type[312+:2];
    wire  [31:0] o_d = sink_data_r[63:32];
    wire  [1:0]  o_t = sink_type_r[3:2];
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            c1_code_r <= 6'h00;
            c1_want_r <= 2'h0;
            c1_den_r  <= 1'b0;
            c1_dflt_r <= 32'h0000_0000;
        end else if (cfg_we && cfg_sink == 3'h1) begin
            c1_code_r <= cfg_code;
            c1_want_r <= cfg_want;
            c1_den_r  <= cfg_dflt_en;
            c1_dflt_r <= cfg_dflt;
        end
    end
    // Reference truncation; sign wins even for negative zero and NaN.
    function automatic logic [31:0] f2u(input logic [31:0] f);
        logic [31:0] m;
        m = {8'h00, 1'b1, f[22:0]};
        if (f[31] || f[30:23] < 8'h7F) f2u = 32'h0000_0000;
        else if (f[30:23] >= 8'h9F) f2u = 32'hFFFF_FFFF;
        else if (f[30:23] >= 8'h96) f2u = m << (f[30:23] - 8'h96);
        else f2u = m >> (8'h96 - f[30:23]);
    endfunction
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    property p_pass; c1_code_r == 6'h27 && c1_want_r == 2'h0 |=> o_d == $past(s_d) && o_t == $past(s_t); endproperty
    a_pass: assert property (p_pass) else $error("pass-through value differs");
    property p_c2d; c1_code_r == 6'h27 && c1_want_r == `SSR_TYPE_DISC && s_t == `SSR_TYPE_CONT
        |=> o_d == f2u($past(s_d)) && o_t == `SSR_TYPE_DISC; endproperty
    a_c2d: assert property (p_c2d) else $error("float to integer result wrong");
    property p_sat; sink_sat_r[1] |-> o_d == 32'hFFFF_FFFF && sink_conv_r[1]; endproperty
    a_sat: assert property (p_sat) else $error("saturation flag without all ones");
    property p_d2c; c1_code_r == 6'h27 && c1_want_r == `SSR_TYPE_CONT && s_t == `SSR_TYPE_DISC
        && s_d < 32'h0100_0000 |=> o_t == `SSR_TYPE_CONT && !o_d[31] && f2u(o_d) == $past(s_d); endproperty
    a_d2c: assert property (p_d2c) else $error("integer to float result wrong");
    property p_undef; c1_code_r == 6'h27 && c1_den_r && s_t == `SSR_TYPE_UNDEF
        |=> o_t == `SSR_TYPE_UNDEF && o_d == $past(c1_dflt_r) && !sink_conv_r[1]; endproperty
    a_undef: assert property (p_undef) else $error("undefined source not given default");
    property p_none; c1_code_r == 6'h00 && !c1_den_r |=> o_t == `SSR_TYPE_UNDEF && o_d == 32'h0; endproperty
    a_none: assert property (p_none) else $error("unconnected input not undefined");
    property p_one; c1_code_r == 6'h2D && c1_want_r != `SSR_TYPE_CONT |=> o_d == 32'h1 && o_t == `SSR_TYPE_DISC;
    endproperty
    a_one: assert property (p_one) else $error("constant one wrong");
    property p_rd; cfg_we ##1 (!cfg_we && $stable(cfg_sink)) |=> rd_code_r == $past(cfg_code, 2); endproperty
    a_rd: assert property (p_rd) else $error("readback of stored code wrong");
endmodule
bind ssr_router ssr_props u_props (.core_clk(core_clk), .rst_n(rst_n), .src_data(src_data), .src_type(src_type),
    .cfg_we(cfg_we), .cfg_sink(cfg_sink), .cfg_code(cfg_code), .cfg_want(cfg_want), .cfg_dflt_en(cfg_dflt_en),
    .cfg_dflt(cfg_dflt), .rd_code_r(rd_code_r), .sink_data_r(sink_data_r), .sink_type_r(sink_type_r),
    .sink_conv_r(sink_conv_r), .sink_sat_r(sink_sat_r));
`default_nettype wire

// [verification/ssr_src_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_src_model (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          set_en,
    input  wire logic [7:0]    set_slot,
    input  wire logic [31:0]   set_data,
    input  wire logic [1:0]    set_type,
    output var  logic [6143:0] src_data,
    output var  logic [383:0]  src_type
);
    // Unset slots carry junk data under an undefined tag, so a missed tag shows.
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_data <= {192{32'hA5C3_5A3C}};
            src_type <= '0;
        end else if (set_en) begin
            src_data[set_slot*32+:32] <= set_data;
            src_type[set_slot*2+:2]   <= set_type;
        end
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ssr_regs.vh"
module tb;
    logic          core_clk, rst_n, cfg_we, cfg_dflt_en, set_en, rd_dflt_en_r;
    logic [2:0]    cfg_sink;
    logic [5:0]    cfg_code, rd_code_r;
    logic [1:0]    cfg_num, cfg_want, set_type, rd_num_r, rd_want_r;
    logic [31:0]   const_disc, const_cont, cfg_dflt, set_data, rd_dflt_r;
    logic [7:0]    set_slot, sink_conv_r, sink_sat_r, sink_upd_r;
    logic [6143:0] src_data;
    logic [383:0]  src_type;
    logic [255:0]  sink_data_r;
    logic [15:0]   sink_type_r;
    integer        fail_count = 0;
    integer        samples_checked = 0;
    ssr_src_model u_src (.core_clk(core_clk), .rst_n(rst_n), .set_en(set_en), .set_slot(set_slot),
        .set_data(set_data), .set_type(set_type), .src_data(src_data), .src_type(src_type));
    ssr_router uut (.core_clk(core_clk), .rst_n(rst_n), .src_data(src_data), .src_type(src_type),
        .const_disc(const_disc), .const_cont(const_cont), .cfg_we(cfg_we), .cfg_sink(cfg_sink),
        .cfg_code(cfg_code), .cfg_num(cfg_num), .cfg_want(cfg_want), .cfg_dflt_en(cfg_dflt_en),
        .cfg_dflt(cfg_dflt), .rd_code_r(rd_code_r), .rd_num_r(rd_num_r), .rd_want_r(rd_want_r),
        .rd_dflt_en_r(rd_dflt_en_r), .rd_dflt_r(rd_dflt_r), .sink_data_r(sink_data_r),
        .sink_type_r(sink_type_r), .sink_conv_r(sink_conv_r), .sink_sat_r(sink_sat_r), .sink_upd_r(sink_upd_r));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Three edges cover the store, the route and the one-cycle output latency.
    task settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task route(input logic [2:0] s, input logic [5:0] c, input logic [1:0] n, input logic [1:0] w,
               input logic de, input logic [31:0] dv);
        @(posedge core_clk);
        cfg_we <= 1'b1; cfg_sink <= s; cfg_code <= c; cfg_num <= n; cfg_want <= w; cfg_dflt_en <= de; cfg_dflt <= dv;
        @(posedge core_clk);
        cfg_we <= 1'b0;
        settle;
    endtask
    task put(input logic [7:0] sl, input logic [31:0] d, input logic [1:0] t);
        @(posedge core_clk);
        set_en <= 1'b1; set_slot <= sl; set_data <= d; set_type <= t;
        @(posedge core_clk);
        set_en <= 1'b0;
        settle;
    endtask
    task sk(input int i, input logic [31:0] d, input logic [1:0] t);
        chk("sink data", sink_data_r[i*32+:32], d);
        chk("sink type", {30'h0, sink_type_r[i*2+:2]}, {30'h0, t});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_fanout;
        for (int i = 0; i < 8; i++) sk(i, 32'h0, `SSR_TYPE_UNDEF);
        for (int i = 0; i < 8; i++) route(i[2:0], `SSR_SRC_CONST_DISC, 2'h0, `SSR_TYPE_DISC, 1'b0, 32'h0);
        for (int i = 0; i < 8; i++) sk(i, 32'h89AB_CDEF, `SSR_TYPE_DISC);
        @(posedge core_clk);
        cfg_sink <= 3'h3;
        repeat (2) @(posedge core_clk);
        #1;
        chk("readback code", {26'h0, rd_code_r}, 32'h2A);
        chk("readback want", {30'h0, rd_want_r}, 32'h1);
    endtask
    task t_consts;
        logic [5:0] cd [4];
        logic [31:0] ev [4];
        logic [1:0] et [4];
        cd = '{6'h00, 6'h2C, 6'h2D, 6'h2B};
        ev = '{32'h0, 32'h0, 32'h1, 32'h3F80_0000};
        et = '{`SSR_TYPE_UNDEF, `SSR_TYPE_DISC, `SSR_TYPE_DISC, `SSR_TYPE_CONT};
        for (int k = 0; k < 4; k++) begin
            route(3'h1, cd[k], 2'h3, 2'h0, 1'b0, 32'h0);
            sk(1, ev[k], et[k]);
        end
    endtask
    task t_slots;
        logic [5:0] cd [7];
        logic [1:0] nm [7];
        cd = '{6'h09, 6'h09, 6'h09, 6'h1D, 6'h26, 6'h2E, 6'h2F};
        nm = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
        for (int k = 0; k < 7; k++) begin
            put({cd[k], nm[k]}, 32'h4120_0000 + k, `SSR_TYPE_CONT);
            route(3'h2, cd[k], nm[k], 2'h0, 1'b0, 32'h0);
            sk(2, 32'h4120_0000 + k, `SSR_TYPE_CONT);
        end
    endtask
    task t_c2d;
        logic [31:0] fi [6];
        logic [31:0] ev [6];
        fi = '{32'h4049_0FDB, 32'hBF80_0000, 32'h8000_0000, 32'h4F80_0000, 32'h4F7F_FFFF, 32'h3F00_0000};
        ev = '{32'h3, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FF00, 32'h0};
        route(3'h1, 6'h27, 2'h0, `SSR_TYPE_DISC, 1'b0, 32'h0);
        for (int k = 0; k < 6; k++) begin
            put(8'h9C, fi[k], `SSR_TYPE_CONT);
            sk(1, ev[k], `SSR_TYPE_DISC);
            chk("saturated", {31'h0, sink_sat_r[1]}, {31'h0, k == 3});
        end
    endtask
    task t_d2c;
        logic [31:0] ui [5];
        logic [31:0] ev [5];
        ui = '{32'h1, 32'h0, 32'h3E8, 32'h5, 32'h00FF_FFFF};
        ev = '{32'h3F80_0000, 32'h0, 32'h447A_0000, 32'h40A0_0000, 32'h4B7F_FFFF};
        route(3'h1, 6'h27, 2'h0, `SSR_TYPE_CONT, 1'b0, 32'h0);
        for (int k = 0; k < 5; k++) begin
            put(8'h9C, ui[k], `SSR_TYPE_DISC);
            sk(1, ev[k], `SSR_TYPE_CONT);
            chk("converted", {31'h0, sink_conv_r[1]}, 32'h1);
        end
    endtask
    task t_undef;
        route(3'h1, 6'h27, 2'h2, `SSR_TYPE_DISC, 1'b1, 32'h0000_1234);
        chk("readback num", {30'h0, rd_num_r}, 32'h2);
        chk("readback default", rd_dflt_r, 32'h0000_1234);
        chk("readback default enable", {31'h0, rd_dflt_en_r}, 32'h1);
        put(8'h9C, 32'h77, `SSR_TYPE_UNDEF);
        sk(1, 32'h0000_1234, `SSR_TYPE_UNDEF);
        route(3'h1, 6'h27, 2'h0, `SSR_TYPE_DISC, 1'b0, 32'h0);
        sk(1, 32'h0, `SSR_TYPE_UNDEF);
        put(8'h9C, 32'hC000_0000, `SSR_TYPE_CONT);
        route(3'h1, 6'h27, 2'h0, 2'h0, 1'b0, 32'h0);
        sk(1, 32'hC000_0000, `SSR_TYPE_CONT);
    endtask
    // The source changes at one edge and the input must show it at the next.
    task t_upd;
        @(posedge core_clk);
        set_en <= 1'b1; set_slot <= 8'h9C; set_data <= 32'h4000_0000; set_type <= `SSR_TYPE_CONT;
        @(posedge core_clk);
        set_en <= 1'b0;
        @(posedge core_clk);
        #1;
        sk(1, 32'h4000_0000, `SSR_TYPE_CONT);
        chk("update flag", {31'h0, sink_upd_r[1]}, 32'h1);
        chk("quiet flag", {31'h0, sink_upd_r[0]}, 32'h0);
        @(posedge core_clk);
        #1;
        chk("update flag", {31'h0, sink_upd_r[1]}, 32'h0);
    endtask
    task t_reset;
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        settle;
        sk(1, 32'h0, `SSR_TYPE_UNDEF);
        chk("readback after reset", {26'h0, rd_code_r}, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0; cfg_we = 1'b0; cfg_sink = 3'h0; cfg_code = 6'h00; cfg_num = 2'h0; cfg_want = 2'h0;
        cfg_dflt_en = 1'b0; cfg_dflt = 32'h0; set_en = 1'b0; set_slot = 8'h00; set_data = 32'h0; set_type = 2'h0;
        const_disc = 32'h89AB_CDEF; const_cont = 32'h3F80_0000;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        settle;
        t_fanout;
        t_consts;
        t_slots;
        t_c2d;
        t_d2c;
        t_undef;
        t_upd;
        t_reset;
        wrap_up;
    end
    // The sequence needs well under 2,000 cycles; this allows many times that.
    initial begin
        #1_000_000;
        fail_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
